// >>> dv/sadc_frame_checker.sv
// assertion checker on the frame control ports
module sadc_frame_checker #(
   parameter CONV_CYC = 667
) (
   input wire        sys_clk_i,
   input wire        rst_b_i,
   input wire        sclk_i,
   input wire        cs_b_i,
   input wire        frame_sync_in_i,
   input wire [15:0] sample_code_i,
   input wire        sdo_o,
   input wire        sdo_oe_o,
   input wire        sample_en_o,
   input wire        conv_busy_o,
   input wire        power_down_o,
   input wire        init_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LO = CONV_CYC - 2;
   localparam int HI = CONV_CYC + 2;
   logic [1:0]  sck_r;
   logic        cs_r, fs_r;
   logic [5:0]  rise_r, csf_r, fsr_r, fsf_r;
   logic [4:0]  rcnt_r, fcnt_r;
   logic [15:0] bcnt_r;
   wire         rise = sck_r[0] & ~sck_r[1];
   wire         fall = ~sck_r[0] & sck_r[1];
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // short edge histories absorb the input synchroniser latency
   always @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         {sck_r, cs_r, fs_r, rise_r, csf_r, fsr_r, fsf_r} <= '0;
         {rcnt_r, fcnt_r, bcnt_r} <= '0;
      end
      else
      begin
         sck_r  <= {sck_r[0], sclk_i};
         cs_r   <= cs_b_i;
         fs_r   <= frame_sync_in_i;
         rise_r <= {rise_r[4:0], rise};
         csf_r  <= {csf_r[4:0], cs_r & ~cs_b_i & frame_sync_in_i};
         fsr_r  <= {fsr_r[4:0], ~fs_r & frame_sync_in_i & ~cs_b_i};
         fsf_r  <= {fsf_r[4:0], fs_r & ~frame_sync_in_i & ~cs_b_i};
         rcnt_r <= !sdo_oe_o ? 5'h00 : rcnt_r + {4'h0, rise};
         fcnt_r <= $rose(sample_en_o) ? 5'h00
                   : fcnt_r + {4'h0, fall & sample_en_o};
         bcnt_r <= conv_busy_o ? bcnt_r + 16'h0001 : 16'h0000;
      end
   a_busy_awake: assert property (conv_busy_o |-> !power_down_o)
      else $error("asleep while converting");
   a_sleep_at_end: assert property
      ($fell(conv_busy_o) && bcnt_r >= LO |-> ##[0:2] power_down_o)
      else $error("no power down after conversion");
   a_conv_length: assert property ($fell(conv_busy_o) |-> bcnt_r <= HI)
      else $error("conversion too long");
   a_start_cause: assert property
      ($rose(sdo_oe_o) |-> (|csf_r) || (|fsr_r) || (|fsf_r))
      else $error("output driven without start edge");
   a_release_cs: assert property
      ($rose(cs_b_i) |-> ##[1:6] !sdo_oe_o)
      else $error("output kept after select rise");
   a_release_17: assert property (sdo_oe_o |-> rcnt_r <= 5'h11)
      else $error("output kept past rise 17");
   a_shift_rise: assert property
      ($changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o) |-> (|rise_r))
      else $error("data changed without clock rise");
   a_conv_closes: assert property
      ($rose(conv_busy_o) |-> $fell(sample_en_o))
      else $error("window not closed at conversion");
   a_window_len: assert property
      ($rose(conv_busy_o) |-> fcnt_r == 5'h14)
      else $error("sampling window length wrong");
   a_init_sticky: assert property (init_done_o |=> init_done_o)
      else $error("init flag dropped");
   cover property ($rose(init_done_o));
   cover property ($fell(conv_busy_o) && bcnt_r < LO);
   cover property ($rose(sdo_oe_o) && (|fsr_r));
endmodule

bind sadc_frame_ctrl sadc_frame_checker #(.CONV_CYC(CONV_CYC)) u_chk (
   .sys_clk_i, .rst_b_i, .sclk_i, .cs_b_i, .frame_sync_in_i, .sample_code_i,
   .sdo_o, .sdo_oe_o, .sample_en_o, .conv_busy_o, .power_down_o,
   .init_done_o);

// >>> dv/sadc_frame_ctrl_tb.sv
// self-checking bench for the serial converter frame control
`include "sadc_regs.vh"
module sadc_frame_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV = 40;
   localparam logic [15:0] RST_W = `SADC_RESET_WORD;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] code_r = 16'h0000;
   logic        sdo, sdo_oe, smp_en, busy, pdn, init;
   logic        sdo_last = 1'b0;
   wire         sclk, cs_b, fs;
   // released line shows the inverse of its last value
   wire         sdo_w = sdo_oe ? sdo : ~sdo_last;
   int          mismatches = 0;
   int          checks_done = 0;
   logic [31:0] rng = 32'h0000AC0F;
   logic [13:0] exp_w = RST_W[15:2];
   logic [15:0] corner [4] = '{16'h0000, 16'h3FFF, 16'hFFFF, 16'h4000};
   always #2 clk = ~clk;
   always @(posedge clk) if (sdo_oe) sdo_last <= sdo;
   sadc_frame_ctrl #(.FS_VARIANT(1), .CONV_CYC(CONV)) dut (
      .sys_clk_i(clk), .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b),
      .frame_sync_in_i(fs), .sample_code_i(code_r), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .sample_en_o(smp_en), .conv_busy_o(busy),
      .power_down_o(pdn), .init_done_o(init));
   sadc_host_model host (.sys_clk_i(clk), .sdo_i(sdo_w), .sclk_o(sclk),
      .cs_b_o(cs_b), .fs_o(fs));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [13:0] clamp(input logic [15:0] c);
      return (c > 16'h3FFF) ? 14'h3FFF : c[13:0];
   endfunction
   task automatic cmp_word(input string n, input logic [13:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cmp_flag(input string n, input logic e, g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // mode 1 leaves the frame open; the next frame sync rise ends it
   task automatic init_cycle(input int mode, input int n);
      logic [15:0] w;
      host.frame(mode, n, w);
      repeat (CONV) @(posedge clk);
      cmp_flag("init flag", 1'b1, init);
      exp_w = RST_W[15:2];
   endtask
   // quick starts the next frame inside the conversion
   task automatic do_frame(input int mode, input logic [15:0] c, bit quick);
      logic [15:0] w;
      @(posedge clk);
      code_r <= c;
      host.frame(mode, 24, w);
      cmp_word("word", exp_w, w[15:2]);
      cmp_flag("drive", 1'b0, sdo_oe);
      exp_w = clamp(c);
      if (quick) exp_w = RST_W[15:2];
      else
      begin
         repeat (CONV + 12) @(posedge clk);
         cmp_flag("sleep", 1'b1, pdn);
      end
   endtask
   initial
   begin
      logic [15:0] c;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      cmp_flag("init flag", 1'b0, init);
      init_cycle(0, 8);
      for (int i = 0; i < 24; i++)
      begin
         rng = xs(rng);
         c = (i < 4) ? corner[i] : rng[15:0];
         if (i == 5 || i == 19) init_cycle(i / 10, 3);
         do_frame(i < 10 ? 0 : i < 17 ? 2 : 1, c, i % 7 == 6);
      end
      results();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule

// >>> dv/sadc_host_model.sv
// serial host model: drives clock and framing, captures the word
module sadc_host_model (
   input  wire logic sys_clk_i,
   input  wire logic sdo_i,
   output logic      sclk_o,
   output logic      cs_b_o,
   output logic      fs_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      fs_o   = 1'b1;
   end
   task automatic half();
      repeat (6) @(posedge sys_clk_i);
   endtask
   // mode 0 select only, 1 frame sync only, 2 both
   task automatic frame(input int mode, input int n, output logic [15:0] w);
      w = 16'h0000;
      if (mode != 0 && fs_o === 1'b1)
      begin
         fs_o <= 1'b0;
         half();
      end
      cs_b_o <= 1'b0;
      if (mode != 0)
      begin
         half();
         fs_o <= 1'b1;
         half();
         fs_o <= 1'b0;
      end
      half();
      for (int k = 1; k <= n; k++)
      begin
         sclk_o <= 1'b1;
         half();
         if (k <= 16) w[16-k] = sdo_i;
         sclk_o <= 1'b0;
         half();
      end
      if (mode != 1) cs_b_o <= 1'b1;
      half();
   endtask
endmodule

// >>> include/sadc_regs.vh
// constants for the serial converter frame control
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// fixed word for reset or abandoned conversion
`define SADC_RESET_WORD      16'h3FC0
`define SADC_ZERO_CODE       14'h0000
`define SADC_FULL_CODE       14'h3FFF
`define SADC_WORD_W          16
`define SADC_RES_W           14
`define SADC_PAD_BITS        2'h0
// counts of serial clock edges within a cycle
`define SADC_RST_MIN_FALLS   5'h01
`define SADC_RST_MAX_FALLS   5'h08
`define SADC_SAMPLE_FALLS    5'h04
`define SADC_CONV_FALLS      5'h18
`define SADC_SDO_LAST_RISE   5'h11
`define SADC_CNT_ONE         5'h01
`define SADC_CNT_ZERO        5'h00
// idle levels of {frame sync, chip select, serial clock}
`define SADC_PIN_IDLE        3'h6
// conversion time
`define SADC_CONV_MAX_NS     2670
`define SADC_CLK_MHZ         250
`define SADC_CONV_CYC        ((`SADC_CONV_MAX_NS * `SADC_CLK_MHZ) / 1000)

`endif

// >>> src/sadc_frame_ctrl.v
// serial framing, reset cycle, pipelined readout and power-down control
//
// What this block does
// - one to eight falling edges then framing release is an init cycle.
// - after a valid init cycle the next word shifted out is 3FC0h.
// - with frame sync, init may start by frame sync falling, ends first rise.
// - sampling window of 20 clocks starts at the fifth clock in frame.
// - conversion starts after 24th falling edge; later chip select rise harmless.
// - new cycle during conversion abandons it; next word is 3FC0h.
// - each cycle shifts out the result of the previous cycle's sample.
// - sixteen bits MSB first, result in 15..2, bits 1..0 don't care.
// - chip select fall with frame sync high starts cycle, MSB out.
// - output bits change on rising clock edges, host captures on falling.
// - frame sync only: its rise starts cycle and presents MSB.
// - both inputs: frame sync rise releases MSB, its fall starts sampling.
// - framing edges are accepted whatever level the serial clock has.
// - single framing input variant: chip select fall starts and shows MSB.
// - results are straight binary, clamped to 0000h and 3FFFh.
// - power down at end of conversion, wake on a start by chip select fall or frame sync rise.
// - output released after 17th rising edge or at chip select rise.
`include "sadc_regs.vh"

module sadc_frame_ctrl #(
   parameter FS_VARIANT = 1,
   parameter CONV_CYC   = `SADC_CONV_CYC
) (
   input  wire        sys_clk_i,
   input  wire        rst_b_i,
   input  wire        sclk_i,
   input  wire        cs_b_i,
   input  wire        frame_sync_in_i,
   input  wire [15:0] sample_code_i,
   output reg         sdo_o,
   output reg         sdo_oe_o,
   output reg         sample_en_o,
   output reg         conv_busy_o,
   output reg         power_down_o,
   output reg         init_done_o
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_ARMED = 2'h1;
   localparam ST_FRAME = 2'h2;
   localparam ST_TAIL  = 2'h3;

   reg         rst_s1_r;
   reg         rst_s2_r;
   wire        rst_n;

   reg  [2:0]  in_s1_r;
   reg  [2:0]  in_s2_r;
   reg  [2:0]  in_s3_r;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [4:0]  fall_cnt_r;
   reg  [4:0]  rise_cnt_r;
   reg  [15:0] shift_r;
   reg  [15:0] next_word_r;
   reg         fs_frame_r;

   wire        sclk_rise;
   wire        sclk_fall;
   wire        cs_low;
   wire        cs_fall;
   wire        cs_rise;
   wire        fs_high;
   wire        fs_rise;
   wire        fs_fall;
   wire        start_cs;
   wire        arm_fs;
   wire        start_fs;
   wire        wake;
   wire        frame_end;
   wire        reach_conv;
   wire        conv_start;
   wire        conv_abort;
   wire        sar_busy;
   wire        sar_done;
   wire [13:0] sar_result;
   wire [15:0] load_word;
   wire        load;

   // reset release through two flops
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   assign rst_n = rst_s2_r;

   // pins: {frame sync, chip select, serial clock}; third stage for edges
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_s1_r <= `SADC_PIN_IDLE;
         in_s2_r <= `SADC_PIN_IDLE;
         in_s3_r <= `SADC_PIN_IDLE;
      end
      else
      begin
         in_s1_r <= {frame_sync_in_i, cs_b_i, sclk_i};
         in_s2_r <= in_s1_r;
         in_s3_r <= in_s2_r;
      end
   end

   // edges are found on the system clock, so framing may move while the
   // serial clock is high or low
   assign sclk_rise = in_s2_r[0] & ~in_s3_r[0];
   assign sclk_fall = ~in_s2_r[0] & in_s3_r[0];
   assign cs_low    = ~in_s2_r[1];
   assign cs_fall   = ~in_s2_r[1] & in_s3_r[1];
   assign cs_rise   = in_s2_r[1] & ~in_s3_r[1];
   // without a frame sync pin it reads as tied high
   assign fs_high   = (FS_VARIANT != 0) ? in_s2_r[2] : 1'b1;
   assign fs_rise   = (FS_VARIANT != 0) & in_s2_r[2] & ~in_s3_r[2];
   assign fs_fall   = (FS_VARIANT != 0) & ~in_s2_r[2] & in_s3_r[2];

   assign start_cs  = cs_fall & fs_high;
   assign arm_fs    = fs_rise & cs_low;
   assign start_fs  = fs_fall & cs_low &
                      ((state_r == ST_ARMED) ||
                       (state_r == ST_IDLE));
   assign wake      = start_cs | arm_fs;

   // frame sync ends a frame only when that frame was opened by it
   assign frame_end = cs_rise | (fs_rise & fs_frame_r);
   assign reach_conv = sclk_fall &
                       (fall_cnt_r == `SADC_CONV_FALLS - `SADC_CNT_ONE);
   assign conv_start = (state_r == ST_FRAME) & ~frame_end & reach_conv;
   // a new cycle while converting throws the conversion away
   assign conv_abort = wake & sar_busy;

   // a cycle never shows a half-finished result
   assign load_word = sar_busy ? `SADC_RESET_WORD : next_word_r;
   // only a start from rest loads; a start inside a frame is ignored
   assign load      = (start_cs | arm_fs) &
                      ((state_r == ST_IDLE) || (state_r == ST_TAIL));

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE, ST_TAIL:
         begin
            if (start_cs)
               state_nxt = ST_FRAME;
            else if (arm_fs)
               state_nxt = ST_ARMED;
            else if (start_fs && state_r == ST_IDLE)
               state_nxt = ST_FRAME;
         end
         ST_ARMED:
         begin
            if (start_fs)
               state_nxt = ST_FRAME;
            else if (cs_rise)
               state_nxt = ST_IDLE;
         end
         ST_FRAME:
         begin
            if (frame_end)
               state_nxt = ST_IDLE;
            else if (reach_conv)
               state_nxt = ST_TAIL;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r      <= ST_IDLE;
         fall_cnt_r   <= `SADC_CNT_ZERO;
         rise_cnt_r   <= `SADC_CNT_ZERO;
         shift_r      <= `SADC_RESET_WORD;
         next_word_r  <= `SADC_RESET_WORD;
         fs_frame_r   <= 1'b0;
         sdo_o        <= 1'b0;
         sdo_oe_o     <= 1'b0;
         sample_en_o  <= 1'b0;
         conv_busy_o  <= 1'b0;
         power_down_o <= 1'b1;
         init_done_o  <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         // busy rises with the engine's own busy, one cycle after the start pulse
         conv_busy_o <= sar_busy | conv_start;

         // fresh result lines up for the next cycle
         if (sar_done)
            next_word_r <= {sar_result, `SADC_PAD_BITS};
         else if (conv_abort)
            next_word_r <= `SADC_RESET_WORD;

         if (sar_done)
            power_down_o <= 1'b1;
         else if (wake)
            power_down_o <= 1'b0;

         // cycle start: MSB goes out at once, counters cleared
         if (load)
         begin
            shift_r    <= load_word;
            sdo_o      <= load_word[`SADC_WORD_W-1];
            sdo_oe_o   <= 1'b1;
            fall_cnt_r <= `SADC_CNT_ZERO;
            rise_cnt_r <= `SADC_CNT_ZERO;
            fs_frame_r <= 1'b0;
         end
         else if (start_fs)
         begin
            // sampling counts from the frame sync fall
            fall_cnt_r <= `SADC_CNT_ZERO;
            rise_cnt_r <= `SADC_CNT_ZERO;
            fs_frame_r <= 1'b1;
            if (state_r == ST_IDLE)
            begin
               shift_r  <= load_word;
               sdo_o    <= load_word[`SADC_WORD_W-1];
               sdo_oe_o <= 1'b1;
            end
         end
         else
         begin
            if (state_r == ST_FRAME && sclk_fall &&
                fall_cnt_r != `SADC_CONV_FALLS)
               fall_cnt_r <= fall_cnt_r + `SADC_CNT_ONE;

            // every rise counts toward the release, but the first one
            // comes before the MSB is taken and must not shift
            if ((state_r == ST_FRAME || state_r == ST_TAIL) && sclk_rise &&
                rise_cnt_r != `SADC_SDO_LAST_RISE)
            begin
               rise_cnt_r <= rise_cnt_r + `SADC_CNT_ONE;
               if (fall_cnt_r != `SADC_CNT_ZERO)
               begin
                  shift_r <= {shift_r[`SADC_WORD_W-2:0], 1'b0};
                  sdo_o   <= shift_r[`SADC_WORD_W-2];
               end
               // 17th rise of the cycle, the first one included
               if (rise_cnt_r == `SADC_SDO_LAST_RISE - `SADC_CNT_ONE)
                  sdo_oe_o <= 1'b0;
            end

            if (cs_rise)
               sdo_oe_o <= 1'b0;

            // a short frame is the reset cycle, any other short one aborts
            if (state_r == ST_FRAME && frame_end)
            begin
               next_word_r <= `SADC_RESET_WORD;
               // a frame sync rise ends the cycle without a select rise
               sdo_oe_o    <= 1'b0;
               if (fall_cnt_r >= `SADC_RST_MIN_FALLS &&
                   fall_cnt_r <= `SADC_RST_MAX_FALLS)
                  init_done_o <= 1'b1;
               fs_frame_r <= 1'b0;
            end
         end

         sample_en_o <= (state_nxt == ST_FRAME) &&
                        (state_r == ST_FRAME) &&
                        (fall_cnt_r >= `SADC_SAMPLE_FALLS);
      end
   end

   // once started the engine runs on regardless of a chip select rise
   sadc_sar_core #(
      .CONV_CYC (CONV_CYC),
      .CNT_W    (12)
   ) u_sar (
      .clk_i    (sys_clk_i),
      .rst_n_i  (rst_n),
      .start_i  (conv_start),
      .abort_i  (conv_abort),
      .sample_i (sample_code_i),
      .busy_o   (sar_busy),
      .done_o   (sar_done),
      .result_o (sar_result)
   );

endmodule

// >>> src/sadc_sar_core.v
// conversion engine: timed on the internal clock, clamps, holds result
`include "sadc_regs.vh"

module sadc_sar_core #(
   parameter CONV_CYC = `SADC_CONV_CYC,
   parameter CNT_W    = 12
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        start_i,
   input  wire        abort_i,
   input  wire [15:0] sample_i,
   output reg         busy_o,
   output reg         done_o,
   output reg  [13:0] result_o
);

   reg [CNT_W-1:0] cnt_r;
   reg [15:0]      held_r;

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         cnt_r    <= {CNT_W{1'b0}};
         held_r   <= 16'h0000;
         result_o <= `SADC_ZERO_CODE;
      end
      else
      begin
         done_o <= 1'b0;
         if (abort_i)
         begin
            busy_o <= 1'b0;
         end
         else if (start_i)
         begin
            busy_o <= 1'b1;
            held_r <= sample_i;
            cnt_r  <= CONV_CYC[CNT_W-1:0];
         end
         else if (busy_o)
         begin
            if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               // inputs at or above the reference saturate
               if (held_r > {2'h0, `SADC_FULL_CODE})
                  result_o <= `SADC_FULL_CODE;
               else
                  result_o <= held_r[13:0];
            end
            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule
